// ---- verilog/mbd_pkg.sv ----
// memory bus decoder: shared map, codes, carriers and timing constants
// assumes a single 20 MHz system clock and an APB register port
package mbd_pkg;

  // target regions; index minus one is the select bit
  typedef enum logic [3:0] {
    RG_NONE, RG_FLASH, RG_XFLASH, RG_RAM, RG_VRAM, RG_PER16, RG_PER32,
    RG_PPB, RG_ROMT, RG_TBSFR, RG_TBSRAM
  } mbd_region_e;

  localparam int NUM_TGT = 10;

  // width and access size share one scale: 0 byte, 1 halfword, 2 word
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
  localparam logic [31:0] FLASH_SIZE = 32'h0001_8000;
  localparam logic [31:0] XFLASH_BASE = 32'h0004_0000;
  localparam logic [31:0] XFLASH_SIZE = 32'h0010_0000;
  localparam logic [31:0] RAM_BASE = 32'h0015_0000;
  localparam logic [31:0] RAM_SIZE = 32'h0000_2000;
  localparam logic [31:0] VRAM_BASE = 32'h0015_2000;
  localparam logic [31:0] VRAM_SIZE = 32'h0000_4800;
  localparam logic [31:0] PER16_BASE = 32'h0020_0000;
  localparam logic [31:0] PER16_SIZE = 32'h0000_1000;
  localparam logic [31:0] PER32_BASE = 32'h0020_1000;
  localparam logic [31:0] PER32_SIZE = 32'h0000_3000;
  localparam logic [31:0] PPB_BASE = 32'hE000_0000;
  localparam logic [31:0] PPB_SIZE = 32'h1000_0000;
  localparam logic [31:0] ROMT_BASE = 32'hF000_0000;
  localparam logic [31:0] ROMT_SIZE = 32'h0000_1000;
  localparam logic [31:0] TBSFR_BASE = 32'hF020_0000;
  localparam logic [31:0] TBSFR_SIZE = 32'h0000_1000;
  localparam logic [31:0] TBSRAM_BASE = 32'hF022_0000;
  localparam logic [31:0] TBSRAM_SIZE = 32'h0000_2000;

  // register port byte addresses
  localparam logic [31:0] PROT_ADDR = 32'h0020_0000;
  localparam logic [31:0] FWAIT_ADDR = 32'h0020_01B0;
  localparam logic [31:0] STAT_ADDR = 32'h0020_01B4;
  localparam logic [15:0] PROT_RESET = 16'h0000;
  localparam logic [1:0] FWAIT_RESET = 2'h0;
  localparam int FWAIT_LSB = 0;
  localparam int STAT_BUSY_BIT = 4;

  // one bus cycle is one system clock period
  localparam int CLK_PERIOD_NS = 50;
  localparam int BEAT_NS = 50;
  localparam int BEAT_CYC_RAW = (BEAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BEAT_CYC = (BEAT_CYC_RAW < 1) ? 1 : BEAT_CYC_RAW;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic write;
    logic [1:0] size;
    logic [31:0] wdata;
  } mbd_req_s;

  typedef struct packed {
    logic [NUM_TGT-1:0] sel;
    logic [31:0] addr;
    logic write;
    logic [3:0] be;
    logic [31:0] wdata;
  } mbd_tgt_s;

endpackage

// ---- verilog/mbd_region_dec.sv ----
// memory bus decoder: address to region and device width lookup
// purely combinational; the caller registers what it keeps
`timescale 1ns/100ps
module mbd_region_dec (
  input wire logic [31:0] addr,
  output mbd_pkg::mbd_region_e region,
  output logic [1:0] width
);

  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] base,
                                  input logic [31:0] size);
    in_rng = (a >= base) && ((a - base) < size);
  endfunction

  always_comb begin
    region = mbd_pkg::RG_NONE;
    width = mbd_pkg::SZ_WORD;
    if (in_rng(addr, mbd_pkg::FLASH_BASE, mbd_pkg::FLASH_SIZE)) begin
      region = mbd_pkg::RG_FLASH;
    end
    else if (in_rng(addr, mbd_pkg::XFLASH_BASE, mbd_pkg::XFLASH_SIZE)) begin
      region = mbd_pkg::RG_XFLASH;
    end
    else if (in_rng(addr, mbd_pkg::RAM_BASE, mbd_pkg::RAM_SIZE)) begin
      region = mbd_pkg::RG_RAM;
    end
    else if (in_rng(addr, mbd_pkg::VRAM_BASE, mbd_pkg::VRAM_SIZE)) begin
      region = mbd_pkg::RG_VRAM;
    end
    else if (in_rng(addr, mbd_pkg::PER16_BASE, mbd_pkg::PER16_SIZE)) begin
      region = mbd_pkg::RG_PER16;
      width = mbd_pkg::SZ_HALF;
    end
    else if (in_rng(addr, mbd_pkg::PER32_BASE, mbd_pkg::PER32_SIZE)) begin
      region = mbd_pkg::RG_PER32;
    end
    else if (in_rng(addr, mbd_pkg::PPB_BASE, mbd_pkg::PPB_SIZE)) begin
      region = mbd_pkg::RG_PPB;
    end
    else if (in_rng(addr, mbd_pkg::ROMT_BASE, mbd_pkg::ROMT_SIZE)) begin
      region = mbd_pkg::RG_ROMT;
    end
    else if (in_rng(addr, mbd_pkg::TBSFR_BASE, mbd_pkg::TBSFR_SIZE)) begin
      region = mbd_pkg::RG_TBSFR;
    end
    else if (in_rng(addr, mbd_pkg::TBSRAM_BASE, mbd_pkg::TBSRAM_SIZE)) begin
      region = mbd_pkg::RG_TBSRAM;
    end
  end

endmodule

// ---- verilog/mbd_memory_bus_decoder.sv ----
// memory bus decoder: core access sequencer, target selects, register port
// assumes the core holds its request until core_ready and sits on clk
//
// Overview of operation
// - take a 32-bit byte address covering four gigabytes for fetch and data.
// - each bus cycle lasts one system clock period, except flash reads, which the wait field stretches.
// - beats are access size over device width, at least one.
// - internal flash of 96 KB sits at the bottom, 32-bit target.
// - address zero decodes to flash, the reset vector base.
// - a 1 MB window forwards to external flash, 32-bit target.
// - 8 KB general ram, 32-bit target, data and code.
// - 18 KB voice ram right above general ram, 32-bit target.
// - peripheral register space starts at the peripheral base.
// - lowest 4 KB of peripheral space is a 16-bit target.
// - next 12 KB of peripheral space is a 32-bit target.
// - rom table, trace buffer registers and trace buffer sram, 32-bit.
// - private peripheral region below the rom table, 32-bit target.
// - flash reads take extra cycles from the 2-bit read wait field.
`timescale 1ns/100ps
module mbd_memory_bus_decoder (
  input wire logic clk,
  input wire logic rst_b,
  input wire mbd_pkg::mbd_req_s core_req,
  output logic core_ready,
  output logic [31:0] core_rdata,
  output mbd_pkg::mbd_tgt_s tgt,
  input wire logic [31:0] tgt_rdata,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  typedef enum logic [1:0] {ST_IDLE, ST_BEAT, ST_DONE} mbd_state_e;

  function automatic logic [3:0] be_of(input logic [1:0] a, input logic [1:0] bs);
    case (bs)
      2'h0: be_of = 4'h1 << a;
      2'h1: be_of = 4'h3 << a;
      default: be_of = 4'hF;
    endcase
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  mbd_pkg::mbd_region_e dec_region;
  logic [1:0] dec_width;
  logic [mbd_pkg::NUM_TGT-1:0] dec_sel;

  mbd_region_dec u_dec (
    .addr(core_req.addr),
    .region(dec_region),
    .width(dec_width)
  );

  genvar g;
  generate
    for (g = 0; g < mbd_pkg::NUM_TGT; g++) begin : g_sel
      assign dec_sel[g] = (dec_region == mbd_pkg::mbd_region_e'(4'(g + 1)));
    end
  endgenerate

  // register port state
  logic [15:0] prot_r, prot_nxt;
  logic [1:0] fwait_r, fwait_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;

  // sequencer state
  mbd_state_e state_r, state_nxt;
  mbd_pkg::mbd_region_e region_r, region_nxt;
  mbd_pkg::mbd_tgt_s tgt_r, tgt_nxt;
  logic [1:0] bsize_r, bsize_nxt;
  logic [1:0] left_r, left_nxt;
  logic [1:0] wait_r, wait_nxt;
  logic [1:0] reload_r, reload_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic accept;
  logic [1:0] acc_bsize;
  logic [1:0] acc_beats;
  logic [2:0] step;
  logic [31:0] next_addr;

  assign accept = (state_r == ST_IDLE) && core_req.valid;

  always_comb begin
    // beat size and count from width and size
    acc_bsize = (core_req.size > dec_width) ? dec_width : core_req.size;
    case (2'(core_req.size - acc_bsize))
      2'h0: acc_beats = 2'h0;
      2'h1: acc_beats = 2'h1;
      default: acc_beats = 2'h3;
    endcase
    step = 3'h1 << bsize_r;
    next_addr = tgt_r.addr + {29'h0, step};
  end

  always_comb begin
    state_nxt = state_r;
    region_nxt = region_r;
    tgt_nxt = tgt_r;
    bsize_nxt = bsize_r;
    left_nxt = left_r;
    wait_nxt = wait_r;
    reload_nxt = reload_r;
    rdata_nxt = rdata_r;
    case (state_r)
      ST_IDLE: begin
        if (core_req.valid) begin
          state_nxt = ST_BEAT;
          region_nxt = dec_region;
          bsize_nxt = acc_bsize;
          left_nxt = acc_beats;
          rdata_nxt = 32'h0000_0000;
          if (dec_region == mbd_pkg::RG_FLASH && !core_req.write) begin
            reload_nxt = 2'(mbd_pkg::BEAT_CYC - 1) + fwait_r;
          end else begin
            reload_nxt = 2'(mbd_pkg::BEAT_CYC - 1);
          end
          wait_nxt = reload_nxt;
          tgt_nxt.sel = dec_sel;
          tgt_nxt.addr = core_req.addr;
          tgt_nxt.write = core_req.write;
          tgt_nxt.be = (dec_region == mbd_pkg::RG_NONE) ? 4'h0 :
                       be_of(core_req.addr[1:0], acc_bsize);
          tgt_nxt.wdata = core_req.wdata;
        end
      end
      ST_BEAT: begin
        if (wait_r != 2'h0) begin
          wait_nxt = 2'(wait_r - 2'h1);
        end else begin
          if (!tgt_r.write) begin
            rdata_nxt = (rdata_r & ~lane_mask(tgt_r.be)) |
                        (tgt_rdata & lane_mask(tgt_r.be));
          end
          if (left_r == 2'h0) begin
            state_nxt = ST_DONE;
            tgt_nxt.sel = '0;
            tgt_nxt.be = 4'h0;
            tgt_nxt.write = 1'b0;
          end else begin
            left_nxt = 2'(left_r - 2'h1);
            wait_nxt = reload_r;
            tgt_nxt.addr = next_addr;
            tgt_nxt.be = be_of(next_addr[1:0], bsize_r);
          end
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      region_r <= mbd_pkg::RG_NONE;
      tgt_r <= '0;
      bsize_r <= mbd_pkg::SZ_BYTE;
      left_r <= 2'h0;
      wait_r <= 2'h0;
      reload_r <= 2'h0;
      rdata_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      region_r <= region_nxt;
      tgt_r <= tgt_nxt;
      bsize_r <= bsize_nxt;
      left_r <= left_nxt;
      wait_r <= wait_nxt;
      reload_r <= reload_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // core stalls until the done cycle
  assign core_ready = (state_r == ST_DONE);
  assign core_rdata = rdata_r;
  assign tgt = tgt_r;

  // register port: one wait state so read data comes from a flop
  logic apb_acc;
  logic apb_mapped;
  logic [31:0] apb_rd;

  always_comb begin
    apb_acc = psel && penable;
    apb_mapped = (paddr == mbd_pkg::PROT_ADDR) || (paddr == mbd_pkg::FWAIT_ADDR) ||
                 (paddr == mbd_pkg::STAT_ADDR);
    apb_rd = 32'h0000_0000;
    case (paddr)
      mbd_pkg::PROT_ADDR: apb_rd[15:0] = prot_r;
      mbd_pkg::FWAIT_ADDR: apb_rd[mbd_pkg::FWAIT_LSB +: 2] = fwait_r;
      mbd_pkg::STAT_ADDR: begin
        apb_rd[3:0] = region_r;
        apb_rd[mbd_pkg::STAT_BUSY_BIT] = (state_r != ST_IDLE);
      end
      default: apb_rd = 32'h0000_0000;
    endcase
  end

  always_comb begin
    prot_nxt = prot_r;
    fwait_nxt = fwait_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    pready_nxt = apb_acc && !pready_r;
    if (apb_acc && !pready_r) begin
      prdata_nxt = pwrite ? 32'h0000_0000 : apb_rd;
      pslverr_nxt = !apb_mapped;
    end
    if (apb_acc && pready_r && pwrite) begin
      if (paddr == mbd_pkg::PROT_ADDR) begin
        prot_nxt = pwdata[15:0];
      end
      if (paddr == mbd_pkg::FWAIT_ADDR) begin
        fwait_nxt = pwdata[mbd_pkg::FWAIT_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prot_r <= mbd_pkg::PROT_RESET;
      fwait_r <= mbd_pkg::FWAIT_RESET;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prot_r <= prot_nxt;
      fwait_r <= fwait_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r && pready_r;

  // checks
  AST_READY_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
    core_ready |=> !core_ready)
    else $error("core_ready held longer than one cycle");

  AST_PER32_ONE: assert property (@(posedge clk) disable iff (!rst_b)
    (accept && dec_region == mbd_pkg::RG_PER32) |=> ##1 core_ready)
    else $error("wide peripheral access did not finish in one beat");

  AST_PER16_WORD: assert property (@(posedge clk) disable iff (!rst_b)
    (accept && dec_region == mbd_pkg::RG_PER16 && core_req.size == mbd_pkg::SZ_WORD)
    |=> !core_ready ##1 !core_ready ##1 core_ready)
    else $error("word to 16-bit target did not take two beats");

  AST_LE_ORDER: assert property (@(posedge clk) disable iff (!rst_b)
    (accept && dec_region == mbd_pkg::RG_PER16 && core_req.size == mbd_pkg::SZ_WORD &&
     core_req.addr[1:0] == 2'h0)
    |=> (tgt.be == 4'h3) ##1 (tgt.be == 4'hC && tgt.addr[1]))
    else $error("split halves out of little-endian order");

  AST_FLASH_WAIT: assert property (@(posedge clk) disable iff (!rst_b)
    (accept && dec_region == mbd_pkg::RG_FLASH && !core_req.write && fwait_r == 2'h3)
    |=> (tgt.sel[0] && !core_ready) [*4] ##1 core_ready)
    else $error("flash read did not stretch by the wait field");

  AST_RESET_VECTOR: assert property (@(posedge clk) disable iff (!rst_b)
    (accept && core_req.addr == mbd_pkg::FLASH_BASE) |=> tgt.sel[0])
    else $error("address zero did not select flash");

  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
    (accept && dec_region == mbd_pkg::RG_NONE)
    |=> (tgt.sel == '0 && tgt.be == 4'h0) ##1 (core_ready && core_rdata == 32'h0000_0000))
    else $error("reserved access selected a target or read nonzero");

  AST_VRAM_ABOVE: assert property (@(posedge clk) disable iff (!rst_b)
    (accept && core_req.addr == mbd_pkg::RAM_BASE + mbd_pkg::RAM_SIZE) |=> tgt.sel[3])
    else $error("voice ram not directly above general ram");

  AST_WAIT_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    (apb_acc && pready_r && pwrite && paddr == mbd_pkg::FWAIT_ADDR)
    |=> fwait_r == $past(pwdata[1:0]))
    else $error("read wait field not updated by register write");

  AST_SEL_ONEHOT: assert property (@(posedge clk) disable iff (!rst_b)
    $onehot0(tgt.sel))
    else $error("more than one target selected");

  AST_WORD_FULL_LANES: assert property (@(posedge clk) disable iff (!rst_b)
    (accept && dec_width == mbd_pkg::SZ_WORD && core_req.size == mbd_pkg::SZ_WORD &&
     dec_region != mbd_pkg::RG_NONE) |=> (tgt.be == 4'hF))
    else $error("word to 32-bit target did not enable all lanes");

  AST_BYTE_ONE_BEAT: assert property (@(posedge clk) disable iff (!rst_b)
    (accept && core_req.size == mbd_pkg::SZ_BYTE &&
     !(dec_region == mbd_pkg::RG_FLASH && !core_req.write)) |=> ##1 core_ready)
    else $error("byte access took more than one beat");

  AST_XFLASH_NO_WAIT: assert property (@(posedge clk) disable iff (!rst_b)
    (accept && dec_region == mbd_pkg::RG_XFLASH) |=> ##1 core_ready)
    else $error("external flash window took extra cycles");

  AST_PER16_NARROW: assert property (@(posedge clk) disable iff (!rst_b)
    (accept && dec_region == mbd_pkg::RG_PER16 && core_req.size != mbd_pkg::SZ_WORD)
    |=> ##1 core_ready)
    else $error("narrow access to 16-bit target took more than one beat");

  AST_BEAT_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == ST_BEAT && wait_r != 2'h0) |=> ($stable(tgt.addr) && $stable(tgt.be)))
    else $error("target request moved during a flash wait");

  AST_PREADY_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  AST_PROT_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    (apb_acc && pready_r && pwrite && paddr == mbd_pkg::PROT_ADDR)
    |=> prot_r == $past(pwdata[15:0]))
    else $error("protect register not updated by register write");

endmodule

// ---- testbench/mbd_tgt_model.sv ----
// target side model: answers each selected target with an address-derived word
// assumes one-hot selects from the decoder, same clock and reset as the decoder
`timescale 1ns/100ps
module mbd_tgt_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire mbd_pkg::mbd_tgt_s tgt,
  output logic [31:0] tgt_rdata
);
  logic [31:0] last_r;
  logic [3:0] idx;
  always_comb begin
    idx = 4'h0;
    for (int i = 0; i < mbd_pkg::NUM_TGT; i++) begin
      if (tgt.sel[i]) begin
        idx = 4'(i + 1);
      end
    end
  end
  // idle bus shows the inverse of the last word so a stale capture cannot match
  assign tgt_rdata = (tgt.sel == '0) ? ~last_r : {idx, tgt.addr[27:1], 1'b1};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_r <= 32'h0;
    end else begin
      last_r <= tgt_rdata;
    end
  end
endmodule

// ---- testbench/memory_bus_decoder_test.sv ----
// testbench: region map, beat counts, flash wait and register port of the decoder
// assumes the target model above and a 20 MHz clock; no checker file
`timescale 1ns/100ps
module memory_bus_decoder_test;
  typedef struct {logic [31:0] a; logic [1:0] sz; int idx;} mbd_row_s;
  localparam logic [1:0] SB = mbd_pkg::SZ_BYTE;
  localparam logic [1:0] SH = mbd_pkg::SZ_HALF;
  localparam logic [1:0] SW = mbd_pkg::SZ_WORD;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  mbd_pkg::mbd_req_s core_req = '0;
  logic core_ready;
  logic [31:0] core_rdata;
  mbd_pkg::mbd_tgt_s tgt;
  logic [31:0] tgt_rdata;
  logic [31:0] paddr = 32'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int err_total = 0;
  int tests_run = 0;
  int cyc_cnt = 0;
  int n;
  logic [31:0] rd;
  logic [9:0] sel;
  logic er;
  logic [3:0] b0, b1;
  logic [31:0] a1;
  logic [31:0] wd;
  logic wf;
  mbd_row_s rows [0:25] = '{
    '{32'h00000000, SW, 1}, '{32'h00017FFC, SW, 1}, '{32'h00018000, SW, 0},
    '{32'h00040000, SW, 2}, '{32'h0013FFFC, SW, 2}, '{32'h00140000, SW, 0},
    '{32'h00150000, SW, 3}, '{32'h00151FFE, SH, 3}, '{32'h00152000, SW, 4},
    '{32'h001567FF, SB, 4}, '{32'h00156800, SW, 0}, '{32'h00200000, SW, 5},
    '{32'h00200FFE, SH, 5}, '{32'h00200FFD, SB, 5}, '{32'h00201000, SW, 6},
    '{32'h00203FFC, SW, 6}, '{32'h00204000, SW, 0}, '{32'hDFFFFFFC, SW, 0},
    '{32'hE0000000, SW, 7}, '{32'hEFFFFFFC, SW, 7}, '{32'hF0000FFC, SW, 8},
    '{32'hF0001000, SW, 0}, '{32'hF0200000, SW, 9}, '{32'hF0201000, SW, 0},
    '{32'hF0221FFC, SW, 10}, '{32'hF0222000, SW, 0}};

  mbd_memory_bus_decoder u_dut (.clk(clk), .rst_b(rst_b), .core_req(core_req),
    .core_ready(core_ready), .core_rdata(core_rdata), .tgt(tgt), .tgt_rdata(tgt_rdata),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  mbd_tgt_model u_tgt (.clk(clk), .rst_b(rst_b), .tgt(tgt), .tgt_rdata(tgt_rdata));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic finish_test();
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk_dat(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_cyc(input string nm, input int e, input int g);
    tests_run++;
    if (g != e) begin
      err_total++;
      $display("MISMATCH %s exp %0d got %0d", nm, e, g);
    end
  endtask

  // core holds the request until the edge that samples core_ready high
  task automatic core_acc(input logic [31:0] a, input logic [1:0] sz, input logic wr);
    @(posedge clk);
    core_req <= '{1'b1, a, wr, sz, 32'h1234ABCD};
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n == 2) begin
        sel = tgt.sel;
        b0 = tgt.be;
        wd = tgt.wdata;
        wf = tgt.write;
      end
      if (n == 3) begin
        b1 = tgt.be;
        a1 = tgt.addr;
      end
    end while (core_ready !== 1'b1 && n < 40);
    if (core_ready !== 1'b1) err_total++;
    rd = core_rdata;
    core_req.valid <= 1'b0;
  endtask

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) err_total++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] exp_rd(input logic [31:0] a, input logic [1:0] sz, input int idx);
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] m;
    lo = {4'(idx), a[27:2], 2'b01};
    hi = {4'(idx), a[27:2], 2'b11};
    if (idx == 0) return 32'h0;
    // narrow target: low halfword from the first beat, high from the second
    if (sz == SW) return (idx == 5) ? {hi[31:16], lo[15:0]} : lo;
    m = (sz == SH) ? (32'h0000FFFF << (a[1] * 16)) : (32'h000000FF << (a[1:0] * 8));
    return (a[1] ? hi : lo) & m;
  endfunction

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      core_acc(rows[i].a, rows[i].sz, 1'b0);
      chk_cyc("cycles", (rows[i].idx == 5 && rows[i].sz == SW) ? 4 : 3, n);
      chk_dat("sel", (rows[i].idx == 0) ? 32'h0 : 32'h1 << (rows[i].idx - 1), {22'h0, sel});
      chk_dat("rdata", exp_rd(rows[i].a, rows[i].sz, rows[i].idx), rd);
    end
    core_acc(32'h00200000, SW, 1'b1);
    chk_dat("split be0", 32'h3, {28'h0, b0});
    chk_dat("split be1", 32'hC, {28'h0, b1});
    chk_dat("split addr1", 32'h00200002, a1);
    chk_dat("write data", 32'h1234ABCD, wd);
    chk_dat("write flag", 32'h1, {31'h0, wf});
    core_acc(32'h00156800, SW, 1'b1);
    chk_dat("rsvd write sel", 32'h0, {22'h0, sel});
    chk_dat("rsvd write be", 32'h0, {28'h0, b0});
    apb(1'b0, mbd_pkg::FWAIT_ADDR, 32'h0);
    chk_dat("wait reset", 32'h0, rd);
    apb(1'b0, mbd_pkg::PROT_ADDR, 32'h0);
    chk_dat("prot reset", 32'h0, rd);
    apb(1'b1, mbd_pkg::PROT_ADDR, 32'hFFFFFFFF);
    apb(1'b0, mbd_pkg::PROT_ADDR, 32'h0);
    chk_dat("prot rw", 32'h0000FFFF, rd);
    apb(1'b0, 32'h00200004, 32'h0);
    chk_dat("unmapped err", 32'h1, {31'h0, er});
    chk_dat("unmapped data", 32'h0, rd);
    for (int w = 0; w < 4; w++) begin
      apb(1'b1, mbd_pkg::FWAIT_ADDR, 32'hFFFFFFFC | 32'(w));
      chk_dat("wait write err", 32'h0, {31'h0, er});
      apb(1'b0, mbd_pkg::FWAIT_ADDR, 32'h0);
      chk_dat("wait field", 32'(w), rd);
      core_acc(32'h00000010, SW, 1'b0);
      chk_cyc("flash read cycles", 3 + w, n);
      chk_dat("flash read data", exp_rd(32'h00000010, SW, 1), rd);
      core_acc(32'h00000010, SW, 1'b1);
      chk_cyc("flash write cycles", 3, n);
      core_acc(32'h00040010, SW, 1'b0);
      chk_cyc("xflash read cycles", 3, n);
    end
    apb(1'b0, mbd_pkg::STAT_ADDR, 32'h0);
    chk_dat("status", 32'(mbd_pkg::RG_XFLASH), rd);
    apb(1'b1, mbd_pkg::STAT_ADDR, 32'hFFFFFFFF);
    chk_dat("status write err", 32'h0, {31'h0, er});
    apb(1'b0, mbd_pkg::STAT_ADDR, 32'h0);
    chk_dat("status kept", 32'(mbd_pkg::RG_XFLASH), rd);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk_dat("reset ready", 32'h0, {31'h0, core_ready});
    chk_dat("reset sel", 32'h0, {22'h0, tgt.sel});
    chk_dat("reset rdata", 32'h0, core_rdata);
    chk_dat("reset pready", 32'h0, {31'h0, pready});
    rst_b <= 1'b1;
    apb(1'b0, mbd_pkg::FWAIT_ADDR, 32'h0);
    chk_dat("wait after reset", 32'h0, rd);
    core_acc(32'h00000000, SW, 1'b0);
    chk_cyc("vector fetch cycles", 3, n);
    chk_dat("vector fetch sel", 32'h1, {22'h0, sel});
    finish_test();
  end
endmodule
